// >>> rtl/osc_consts.vh
// Constants for the operating-system control and index instruction unit
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
// Opcode bytes and prefixes
`define OSC_P111       8'h49
`define OSC_P113       8'h4B
`define OSC_P115       8'h4D
`define OSC_P117       8'h4F
`define OSC_P062       8'h32
`define OSC_P174       8'h7C
`define OSC_P176       8'h7E
`define OSC_OP_DPS_BC  8'h56
`define OSC_OP_DPS_DE  8'h66
`define OSC_OP_DPS_HL  8'h76
`define OSC_OP_IDXADD  8'h05
`define OSC_OP_IDXSUB  8'h15
`define OSC_OP_BRL     8'h3A
`define OSC_OP_SKIP    8'h25
`define OSC_OP_SYSCALL 8'h37
`define OSC_OP_BRKPT   8'h2A
`define OSC_OP_LEAVE   8'h42
`define OSC_OP_SMLOAD  8'h3F
`define OSC_OP_IEOP    8'h28
// Fixed call targets
`define OSC_SYSCALL_ADDR 16'hEF2A
`define OSC_BRKPT_ADDR   16'hEF30
// Sector map: six stored bits, section in [5:2], write enable [1], access enable [0]
`define OSC_SECT_LAST    4'hF
`define OSC_SECT_CALL    6'h3D
`define OSC_SECT_RST     6'h00
// Instruction lengths and index of the last fetched byte
`define OSC_LEN1 16'h0001
`define OSC_LEN2 16'h0002
`define OSC_LEN3 16'h0003
`define OSC_LEN4 16'h0004
`define OSC_LEN5 16'h0005
`define OSC_FETCH_LAST 3'h4
// Sector map load cycles at 10 ns: 3.2 us plus 1.8 us per entry
`define OSC_SML_BASE_CYC 12'h140
`define OSC_SML_PER_CYC  12'h0B4
`endif

// >>> rtl/osc_exec.v
// Executes paged double store, memory index and operating-system control instructions
// Notes on behaviour
// RQ1 - Double paged store writes pair low byte at {X,operand}, high byte one above.
// RQ2 - Index is a 16-bit word at {X,index byte}, high byte at next address.
// RQ3 - Short forms take one displacement byte; 111-prefixed forms take two, low first.
// RQ4 - Index add/subtract rewrites the index; carry shows carry or borrow out.
// RQ5 - Load-from-index forms put index plus/minus displacement in a pair, same carry.
// RQ6 - Base register load copies named register or A; no way to read it back.
// RQ7 - Base load and sector map load trap as privileged when user flag is set.
// RQ8 - Skip-jump is three bytes, steps the program counter past it, never jumps.
// RQ9 - System call clears user flag, maps last entry to last 4K, calls ROM.
// RQ10 - Breakpoint acts as system call but calls the fixed debug RAM location.
// RQ11 - Leave-to-unprivileged is a plain return that also sets the user flag.
// RQ12 - Sector map load copies C entries from HL; no register or flag changes.
// RQ13 - Entries hold six bits: section, write enable, access enable; two low unused.
// RQ14 - Sector map load takes 3.2 plus 1.8 per entry time units; one byte.
// RQ15 - Enable-and-branch is four bytes, enables interrupts, jumps to operand address.
// RQ16 - Enable-and-leave is two bytes: enable interrupts, set user flag, return.
// RQ17 - Unmaskable interrupts such as parity fault vector even with interrupts off.
// RQ18 - A trapped privileged instruction leaves no architectural effect at all.
`include "osc_consts.vh"

module osc_exec (
   input  wire        clk_sys_i,
   input  wire        rst_i,
   input  wire        start_i,
   input  wire [15:0] pc_i,
   input  wire [7:0]  reg_a_i,
   input  wire [7:0]  reg_b_i,
   input  wire [7:0]  reg_c_i,
   input  wire [7:0]  reg_d_i,
   input  wire [7:0]  reg_e_i,
   input  wire [7:0]  reg_h_i,
   input  wire [7:0]  reg_l_i,
   input  wire [7:0]  reg_x_i,
   input  wire [15:0] ret_addr_i,
   input  wire        irq_req_i,
   input  wire        nmi_req_i,
   input  wire [3:0]  sect_idx_i,
   input  wire [7:0]  mem_rdata_i,
   output reg         busy_o,
   output reg         done_o,
   output reg  [15:0] pc_o,
   output reg  [15:0] mem_addr_o,
   output reg         mem_rd_o,
   output reg         mem_wr_o,
   output reg  [7:0]  mem_wdata_o,
   output reg         pair_wr_o,
   output reg  [1:0]  pair_sel_o,
   output reg  [15:0] pair_data_o,
   output reg         carry_wr_o,
   output reg         carry_o,
   output reg         push_o,
   output reg  [15:0] push_data_o,
   output reg         pop_o,
   output reg  [7:0]  base_o,
   output reg         user_mode_o,
   output reg         irq_en_o,
   output reg         priv_trap_o,
   output reg         illegal_o,
   output reg         irq_take_o,
   output reg         nmi_take_o,
   output reg  [5:0]  sect_entry_o
);

   localparam ST_IDLE  = 3'd0;
   localparam ST_FETCH = 3'd1;
   localparam ST_DEC   = 3'd2;
   localparam ST_IRD   = 3'd3;
   localparam ST_IEXE  = 3'd4;
   localparam ST_WR2   = 3'd5;
   localparam ST_SML   = 3'd6;
   localparam ST_PAD   = 3'd7;

   reg  [2:0]  st_q;
   reg  [2:0]  fc_q;
   reg         pend_q;
   reg  [15:0] pcb_q;
   reg  [7:0]  ib_q [0:4];
   reg  [11:0] cyc_q;
   reg  [11:0] tgt_q;
   reg  [15:0] disp_q;
   reg  [7:0]  idx_q;
   reg         sub_q;
   reg         wb_q;
   reg  [1:0]  psel_q;
   reg  [15:0] len_q;
   reg         hi_q;
   reg  [7:0]  ilo_q;
   reg  [15:0] a2_q;
   reg  [7:0]  d2_q;
   reg  [3:0]  sk_q;
   reg  [3:0]  sn_q;
   reg         swe_q;
   reg  [3:0]  swi_q;
   reg  [5:0]  swd_q;
   reg  [5:0]  sect_q [0:15];

   wire [7:0]  b0 = ib_q[0];
   wire [7:0]  b1 = ib_q[1];
   wire [7:0]  b2 = ib_q[2];
   wire [7:0]  b3 = ib_q[3];
   wire [7:0]  b4 = ib_q[4];
   wire        b1_idx = (b1 == `OSC_OP_IDXADD) || (b1 == `OSC_OP_IDXSUB);
   wire        dps_bc = (b0 == `OSC_P111) && (b1 == `OSC_OP_DPS_BC);
   wire        dps_de = (b0 == `OSC_P113) && (b1 == `OSC_OP_DPS_DE);
   wire        dps_hl = (b0 == `OSC_P115) && (b1 == `OSC_OP_DPS_HL);
   wire        ix_s   = (b0 == `OSC_OP_IDXADD) || (b0 == `OSC_OP_IDXSUB);
   wire        ix_l   = (b0 == `OSC_P111) && b1_idx;
   wire        lf_s   = ((b0 == `OSC_P062) || (b0 == `OSC_P174) || (b0 == `OSC_P176)) && b1_idx;
   wire        lf_l   = ((b0 == `OSC_P113) || (b0 == `OSC_P115) || (b0 == `OSC_P117)) && b1_idx;
   wire [1:0]  lf_sel = ((b0 == `OSC_P062) || (b0 == `OSC_P113)) ? 2'd0 :
                        ((b0 == `OSC_P174) || (b0 == `OSC_P115)) ? 2'd1 : 2'd2;
   wire        brl_a  = (b0 == `OSC_OP_BRL);
   wire        brl_r  = (b1 == `OSC_OP_BRL) && (b0[7:3] == 5'h00);
   wire [16:0] isum   = sub_q ? ({1'b0, mem_rdata_i, ilo_q} - {1'b0, disp_q})
                              : ({1'b0, mem_rdata_i, ilo_q} + {1'b0, disp_q});
   wire [11:0] sml_tgt = `OSC_SML_BASE_CYC + {8'h00, reg_c_i[3:0]} * `OSC_SML_PER_CYC;

   function [7:0] reg_pick;
      input [2:0] sel;
      begin
         case (sel)
            3'd0: reg_pick = reg_a_i;
            3'd1: reg_pick = reg_b_i;
            3'd2: reg_pick = reg_c_i;
            3'd3: reg_pick = reg_d_i;
            3'd4: reg_pick = reg_e_i;
            3'd5: reg_pick = reg_h_i;
            3'd6: reg_pick = reg_l_i;
            default: reg_pick = reg_x_i;
         endcase
      end
   endfunction

   // Table writes land one cycle after the strobe; readers never see a half-written entry
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_sect
         always @(posedge clk_sys_i) begin
            if (rst_i) begin
               sect_q[gi] <= `OSC_SECT_RST;
            end else if (swe_q && (swi_q == gi)) begin
               sect_q[gi] <= swd_q; // [RQ13]
            end
         end
      end
   endgenerate

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         sect_entry_o <= `OSC_SECT_RST;
      end else begin
         sect_entry_o <= sect_q[sect_idx_i];
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_q <= ST_IDLE;
         fc_q <= 3'd0;
         pend_q <= 1'b0;
         cyc_q <= 12'h000;
         // Internal datapath registers are loaded before use; only control state and the outputs are reset
         swe_q <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         pc_o <= 16'h0000;
         mem_addr_o <= 16'h0000;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         mem_wdata_o <= 8'h00;
         pair_wr_o <= 1'b0;
         pair_sel_o <= 2'd0;
         pair_data_o <= 16'h0000;
         carry_wr_o <= 1'b0;
         carry_o <= 1'b0;
         push_o <= 1'b0;
         push_data_o <= 16'h0000;
         pop_o <= 1'b0;
         base_o <= 8'h00;
         user_mode_o <= 1'b0;
         irq_en_o <= 1'b0;
         priv_trap_o <= 1'b0;
         illegal_o <= 1'b0;
         irq_take_o <= 1'b0;
         nmi_take_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         pair_wr_o <= 1'b0;
         carry_wr_o <= 1'b0;
         push_o <= 1'b0;
         pop_o <= 1'b0;
         priv_trap_o <= 1'b0;
         illegal_o <= 1'b0;
         irq_take_o <= 1'b0;
         nmi_take_o <= 1'b0;
         swe_q <= 1'b0;
         cyc_q <= cyc_q + 12'h001;
         case (st_q)
            ST_IDLE: begin
               if (nmi_req_i) begin
                  nmi_take_o <= 1'b1; // [RQ17]
               end else if (irq_req_i && irq_en_o) begin
                  irq_take_o <= 1'b1;
               end else if (start_i) begin
                  pcb_q <= pc_i;
                  fc_q <= 3'd0;
                  pend_q <= 1'b0;
                  cyc_q <= 12'h000;
                  busy_o <= 1'b1;
                  st_q <= ST_FETCH;
               end
            end
            // Always reads five bytes; surplus reads are harmless and keep decode flat
            ST_FETCH: begin
               if (!pend_q) begin
                  mem_addr_o <= pcb_q + {13'h0000, fc_q};
                  mem_rd_o <= 1'b1;
                  pend_q <= 1'b1;
               end else begin
                  ib_q[fc_q] <= mem_rdata_i;
                  pend_q <= 1'b0;
                  if (fc_q == `OSC_FETCH_LAST) begin
                     st_q <= ST_DEC;
                  end else begin
                     fc_q <= fc_q + 3'd1;
                  end
               end
            end
            ST_DEC: begin
               done_o <= 1'b1;
               busy_o <= 1'b0;
               st_q <= ST_IDLE;
               if (dps_bc || dps_de || dps_hl) begin
                  mem_addr_o <= {reg_x_i, b2}; // [RQ1]
                  mem_wdata_o <= dps_bc ? reg_c_i : (dps_de ? reg_e_i : reg_l_i);
                  mem_wr_o <= 1'b1;
                  a2_q <= {reg_x_i, b2} + 16'h0001;
                  d2_q <= dps_bc ? reg_b_i : (dps_de ? reg_d_i : reg_h_i);
                  len_q <= `OSC_LEN3;
                  done_o <= 1'b0;
                  busy_o <= 1'b1;
                  st_q <= ST_WR2;
               end else if (ix_s || ix_l || lf_s || lf_l) begin
                  sub_q <= ix_s ? (b0 == `OSC_OP_IDXSUB) : (b1 == `OSC_OP_IDXSUB);
                  wb_q <= ix_s || ix_l; // [RQ4]
                  psel_q <= lf_sel;
                  if (ix_s) begin
                     disp_q <= {8'h00, b1}; // [RQ3]
                     idx_q <= b2;
                     len_q <= `OSC_LEN3;
                  end else if (lf_s) begin
                     disp_q <= {8'h00, b2}; // [RQ3]
                     idx_q <= b3;
                     len_q <= `OSC_LEN4;
                  end else begin
                     disp_q <= {b3, b2}; // [RQ3]
                     idx_q <= b4;
                     len_q <= `OSC_LEN5;
                  end
                  hi_q <= 1'b0;
                  pend_q <= 1'b0;
                  done_o <= 1'b0;
                  busy_o <= 1'b1;
                  st_q <= ST_IRD;
               end else if (brl_a || brl_r) begin
                  if (user_mode_o) begin
                     priv_trap_o <= 1'b1; // [RQ7] [RQ18]
                     pc_o <= pcb_q;
                  end else begin
                     base_o <= brl_a ? reg_a_i : reg_pick(b0[2:0]); // [RQ6]
                     pc_o <= pcb_q + (brl_a ? `OSC_LEN1 : `OSC_LEN2);
                  end
               end else if (b0 == `OSC_OP_SKIP) begin
                  pc_o <= pcb_q + `OSC_LEN3; // [RQ8]
               end else if ((b0 == `OSC_OP_SYSCALL) || (b0 == `OSC_OP_BRKPT)) begin
                  user_mode_o <= 1'b0; // [RQ9]
                  swe_q <= 1'b1;
                  swi_q <= `OSC_SECT_LAST;
                  swd_q <= `OSC_SECT_CALL;
                  push_o <= 1'b1;
                  push_data_o <= pcb_q + `OSC_LEN1;
                  pc_o <= (b0 == `OSC_OP_SYSCALL) ? `OSC_SYSCALL_ADDR : `OSC_BRKPT_ADDR; // [RQ9] [RQ10]
               end else if ((b0 == `OSC_P111) && (b1 == `OSC_OP_LEAVE)) begin
                  pop_o <= 1'b1; // [RQ11]
                  pc_o <= ret_addr_i;
                  user_mode_o <= 1'b1;
               end else if (b0 == `OSC_OP_SMLOAD) begin
                  if (user_mode_o) begin
                     priv_trap_o <= 1'b1; // [RQ7] [RQ18]
                     pc_o <= pcb_q;
                  end else begin
                     sk_q <= 4'h0;
                     sn_q <= reg_c_i[3:0];
                     tgt_q <= sml_tgt; // [RQ14]
                     pend_q <= 1'b0;
                     len_q <= `OSC_LEN1;
                     done_o <= 1'b0;
                     busy_o <= 1'b1;
                     st_q <= ST_SML;
                  end
               end else if ((b0 == `OSC_P111) && (b1 == `OSC_OP_IEOP)) begin
                  irq_en_o <= 1'b1; // [RQ15]
                  pc_o <= {b3, b2};
               end else if ((b0 == `OSC_P062) && (b1 == `OSC_OP_IEOP)) begin
                  irq_en_o <= 1'b1; // [RQ16]
                  user_mode_o <= 1'b1;
                  pop_o <= 1'b1;
                  pc_o <= ret_addr_i;
               end else begin
                  illegal_o <= 1'b1;
                  pc_o <= pcb_q;
               end
            end
            ST_IRD: begin
               if (!pend_q) begin
                  mem_addr_o <= {reg_x_i, idx_q} + {15'h0000, hi_q}; // [RQ2]
                  mem_rd_o <= 1'b1;
                  pend_q <= 1'b1;
               end else if (!hi_q) begin
                  ilo_q <= mem_rdata_i;
                  hi_q <= 1'b1;
                  pend_q <= 1'b0;
               end else begin
                  st_q <= ST_IEXE;
                  carry_wr_o <= 1'b1; // [RQ4] [RQ5]
                  carry_o <= isum[16];
                  if (wb_q) begin
                     mem_addr_o <= {reg_x_i, idx_q}; // [RQ4]
                     mem_wdata_o <= isum[7:0];
                     mem_wr_o <= 1'b1;
                     a2_q <= {reg_x_i, idx_q} + 16'h0001;
                     d2_q <= isum[15:8];
                  end else begin
                     pair_wr_o <= 1'b1; // [RQ5]
                     pair_sel_o <= psel_q;
                     pair_data_o <= isum[15:0];
                  end
               end
            end
            ST_IEXE: begin
               if (wb_q) begin
                  mem_addr_o <= a2_q;
                  mem_wdata_o <= d2_q;
                  mem_wr_o <= 1'b1;
               end
               pc_o <= pcb_q + len_q;
               done_o <= 1'b1;
               busy_o <= 1'b0;
               st_q <= ST_IDLE;
            end
            ST_WR2: begin
               mem_addr_o <= a2_q; // [RQ1]
               mem_wdata_o <= d2_q;
               mem_wr_o <= 1'b1;
               pc_o <= pcb_q + len_q;
               done_o <= 1'b1;
               busy_o <= 1'b0;
               st_q <= ST_IDLE;
            end
            // Entries go in from the first position upward; low two bits of each byte dropped
            ST_SML: begin
               if (sn_q == 4'h0) begin
                  st_q <= ST_PAD;
               end else if (!pend_q) begin
                  mem_addr_o <= {reg_h_i, reg_l_i} + {12'h000, sk_q}; // [RQ12]
                  mem_rd_o <= 1'b1;
                  pend_q <= 1'b1;
               end else begin
                  swe_q <= 1'b1;
                  swi_q <= sk_q;
                  swd_q <= mem_rdata_i[7:2]; // [RQ13]
                  sk_q <= sk_q + 4'h1;
                  sn_q <= sn_q - 4'h1;
                  pend_q <= 1'b0;
               end
            end
            // Holds completion until the documented duration has elapsed
            ST_PAD: begin
               if (cyc_q >= tgt_q - 12'h001) begin
                  pc_o <= pcb_q + len_q; // [RQ14]
                  done_o <= 1'b1;
                  busy_o <= 1'b0;
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               busy_o <= 1'b0;
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // osc_exec

// >>> sim/osc_exec_chk.sv
// Concurrent checks on the ports of the instruction unit
module osc_exec_chk (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        nmi_req_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic [15:0] pc_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic        mem_wr_o,
   input wire logic        pair_wr_o,
   input wire logic        carry_wr_o,
   input wire logic        push_o,
   input wire logic        pop_o,
   input wire logic [7:0]  base_o,
   input wire logic        user_mode_o,
   input wire logic        irq_en_o,
   input wire logic        priv_trap_o,
   input wire logic        irq_take_o,
   input wire logic        nmi_take_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_PAIR_WRITES: assert property (
      mem_wr_o && !done_o |=> mem_wr_o && done_o && mem_addr_o == $past(mem_addr_o) + 16'h0001)
      else $error("second byte write missing or misplaced");
   AST_CARRY_LAST: assert property (
      carry_wr_o |-> ##1 done_o) else $error("carry update not one cycle before done");
   AST_PAIR_CARRY: assert property (
      pair_wr_o |-> carry_wr_o) else $error("pair load without carry update");
   AST_TRAP_USER: assert property (
      priv_trap_o |-> done_o && $past(user_mode_o)) else $error("trap outside user state");
   AST_TRAP_CLEAN: assert property (
      priv_trap_o |-> !mem_wr_o && !pair_wr_o && base_o == $past(base_o)) else $error("trapped op left an effect");
   AST_CALL: assert property (
      push_o |-> done_o && !user_mode_o && (pc_o == 16'hEF2A || pc_o == 16'hEF30))
      else $error("call target or user state wrong");
   AST_RETURN: assert property (
      pop_o |-> done_o && user_mode_o) else $error("return without user state");
   AST_IRQ_EN: assert property (
      $rose(irq_en_o) |-> done_o) else $error("interrupt enable rose outside completion");
   AST_IRQ_MASK: assert property (
      irq_take_o |-> $past(irq_en_o)) else $error("masked interrupt was taken");
   AST_NMI: assert property (
      $rose(nmi_req_i) && !busy_o |-> ##[1:3] nmi_take_o) else $error("unmaskable interrupt not taken");
   COV_CALL: cover property (push_o);
   COV_TRAP: cover property (priv_trap_o);
   COV_PAIR: cover property (pair_wr_o);
endmodule // osc_exec_chk

bind osc_exec osc_exec_chk u_chk (.clk_sys_i, .rst_i, .nmi_req_i, .busy_o, .done_o, .pc_o, .mem_addr_o,
   .mem_wr_o, .pair_wr_o, .carry_wr_o, .push_o, .pop_o, .base_o, .user_mode_o, .irq_en_o, .priv_trap_o,
   .irq_take_o, .nmi_take_o);

// >>> sim/osc_mem_model.sv
// Byte-wide main memory model holding code, indices and data
module osc_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic        mem_rd_i,
   input  wire logic        mem_wr_i,
   input  wire logic [7:0]  mem_wdata_i,
   output wire logic [7:0]  mem_rdata_o
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_q = 8'h00;
   // Idle bus shows the inverse of the last byte
   assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last_q;
   always @(posedge clk_sys_i) begin
      if (mem_rd_i) last_q <= mem[mem_addr_i];
      if (mem_wr_i) mem[mem_addr_i] <= mem_wdata_i;
   end
endmodule // osc_mem_model

// >>> sim/os_control_and_index_ops_bench.sv
// Self-checking bench for the control and index instruction unit
module os_control_and_index_ops_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, irq_req_i = 1'b0, nmi_req_i = 1'b0;
   logic [15:0] pc_i = 16'h0000, ret_addr_i = 16'h0000;
   logic [7:0]  reg_a_i = 8'h00, reg_b_i = 8'h00, reg_c_i = 8'h00, reg_d_i = 8'h00;
   logic [7:0]  reg_e_i = 8'h00, reg_h_i = 8'h00, reg_l_i = 8'h00, reg_x_i = 8'h00;
   logic [3:0]  sect_idx_i = 4'h0;
   wire         busy_o, done_o, mem_rd_o, mem_wr_o, pair_wr_o, carry_wr_o, carry_o, push_o, pop_o;
   wire         user_mode_o, irq_en_o, priv_trap_o, illegal_o, irq_take_o, nmi_take_o;
   wire [15:0]  pc_o, mem_addr_o, pair_data_o, push_data_o;
   wire [7:0]   mem_wdata_o, base_o, mem_rdata_i;
   wire [1:0]   pair_sel_o;
   wire [5:0]   sect_entry_o;
   logic [15:0] got_pair, got_push;
   logic [1:0]  got_sel;
   logic        got_carry, got_trap, got_pop, got_ill, got_irq = 1'b0, got_nmi = 1'b0;
   int          errors = 0, tests_run = 0;
   osc_exec u_dut (.clk_sys_i, .rst_i, .start_i, .pc_i, .reg_a_i, .reg_b_i, .reg_c_i, .reg_d_i, .reg_e_i,
      .reg_h_i, .reg_l_i, .reg_x_i, .ret_addr_i, .irq_req_i, .nmi_req_i, .sect_idx_i, .mem_rdata_i, .busy_o,
      .done_o, .pc_o, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .pair_wr_o, .pair_sel_o, .pair_data_o,
      .carry_wr_o, .carry_o, .push_o, .push_data_o, .pop_o, .base_o, .user_mode_o, .irq_en_o, .priv_trap_o,
      .illegal_o, .irq_take_o, .nmi_take_o, .sect_entry_o);
   osc_mem_model u_mem (.clk_sys_i, .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
      .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
   always #5 clk_sys_i = ~clk_sys_i;
   // One-cycle pulses are latched for later checks
   always @(posedge clk_sys_i) begin
      if (pair_wr_o === 1'b1) {got_pair, got_sel} <= {pair_data_o, pair_sel_o};
      if (carry_wr_o === 1'b1) got_carry <= carry_o;
      if (push_o === 1'b1) got_push <= push_data_o;
      if (priv_trap_o === 1'b1) got_trap <= 1'b1;
      if (illegal_o === 1'b1) got_ill <= 1'b1;
      if (pop_o === 1'b1) got_pop <= 1'b1;
      if (irq_take_o === 1'b1) got_irq <= 1'b1;
      if (nmi_take_o === 1'b1) got_nmi <= 1'b1;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put16(input logic [15:0] a, input logic [15:0] v);
      u_mem.mem[a] = v[7:0];
      u_mem.mem[a + 16'h0001] = v[15:8];
   endtask
   function automatic logic [15:0] w16(input logic [15:0] a);
      return {u_mem.mem[a + 16'h0001], u_mem.mem[a]};
   endfunction
   task automatic exec(input logic [15:0] pc, input logic [39:0] code, output int n);
      for (int k = 0; k < 5; k++) u_mem.mem[pc + k] = code[39 - 8 * k -: 8];
      {got_pair, got_push, got_sel, got_carry} = 'x;
      {got_trap, got_pop, got_ill} = 3'b000;
      pc_i = pc;
      start_i = 1'b1;
      @(negedge clk_sys_i);
      start_i = 1'b0;
      n = 0;
      while (n < 4000 && done_o !== 1'b1) begin
         @(negedge clk_sys_i);
         n++;
      end
      // Let the high-byte write land
      @(negedge clk_sys_i);
   endtask
   task automatic settle;
      for (int k = 0; k < 100 && busy_o !== 1'b0; k++) @(negedge clk_sys_i);
      chk("idle", 16'h0000, busy_o);
   endtask
   task automatic sect(input logic [3:0] idx, input logic [5:0] exp);
      sect_idx_i = idx;
      @(negedge clk_sys_i);
      chk("sector entry", {10'h000, exp}, {10'h000, sect_entry_o});
   endtask
   task automatic t_dps;
      int n;
      logic [15:0] a;
      {reg_b_i, reg_c_i, reg_d_i, reg_e_i, reg_h_i, reg_l_i, reg_x_i} = 56'hA1A2_A3A4_A5A6_12;
      for (int i = 0; i < 3; i++) begin
         a = (i == 2) ? 16'h12FF : 16'h1230 + 16'(i);
         exec(16'h0100, {8'h49 + 8'(2 * i), 8'h56 + 8'(16 * i), a[7:0], 16'h0000}, n);
         chk("dps cycles", 16'h000C, 16'(n));
         chk("dps low", {8'h00, 8'hA2 + 8'(2 * i)}, {8'h00, u_mem.mem[a]});
         chk("dps high", {8'h00, 8'hA1 + 8'(2 * i)}, {8'h00, u_mem.mem[a + 16'h0001]});
         chk("dps pc", 16'h0103, pc_o);
      end
   endtask
   task automatic t_idx;
      int n;
      put16(16'h12FE, 16'hFFF8);
      exec(16'h0110, 40'h0510FE0000, n);
      chk("add cycles", 16'h0010, 16'(n));
      chk("add index", 16'h0008, w16(16'h12FE));
      chk("add carry", 16'h0001, got_carry);
      chk("add pc", 16'h0113, pc_o);
      put16(16'h1240, 16'h0100);
      exec(16'h0120, 40'h4915000240, n);
      chk("sub index", 16'hFF00, w16(16'h1240));
      chk("sub borrow", 16'h0001, got_carry);
      chk("sub pc", 16'h0125, pc_o);
   endtask
   task automatic t_lfi;
      int n;
      put16(16'h1250, 16'h1234);
      exec(16'h0130, 40'h7C15355000, n);
      chk("lfi diff", 16'h11FF, got_pair);
      chk("lfi diff pair", 16'h0001, got_sel);
      chk("lfi diff borrow", 16'h0000, got_carry);
      chk("lfi index kept", 16'h1234, w16(16'h1250));
      chk("lfi diff pc", 16'h0134, pc_o);
      put16(16'h1260, 16'h8000);
      exec(16'h0140, 40'h4F05018060, n);
      chk("lfi sum", 16'h0001, got_pair);
      chk("lfi sum pair", 16'h0002, got_sel);
      chk("lfi sum carry", 16'h0001, got_carry);
      chk("lfi sum pc", 16'h0145, pc_o);
   endtask
   task automatic t_base_skip;
      int n;
      reg_a_i = 8'h77;
      exec(16'h0150, 40'h3A00000000, n);
      chk("base from a", 16'h0077, base_o);
      chk("base pc", 16'h0151, pc_o);
      exec(16'h0160, 40'h073A000000, n);
      chk("base from x", 16'h0012, base_o);
      chk("base named pc", 16'h0162, pc_o);
      exec(16'h0170, 40'h2500010000, n);
      chk("skip pc", 16'h0173, pc_o);
      exec(16'h01D0, 40'hFF00000000, n);
      chk("illegal", 16'h0001, got_ill);
   endtask
   task automatic t_sml;
      int n;
      {reg_h_i, reg_l_i, reg_c_i} = 24'h200002;
      u_mem.mem[16'h2000] = 8'h5C; // unused low bits written as zero
      u_mem.mem[16'h2001] = 8'hA4;
      exec(16'h0180, 40'h3F00000000, n);
      chk("map load cycles", 16'h02A8, 16'(n));
      chk("map load pc", 16'h0181, pc_o);
      chk("map load pair", 16'hXXXX, got_pair);
      sect(4'h0, 6'h17);
      sect(4'h1, 6'h29);
      sect(4'h2, 6'h00);
   endtask
   task automatic t_irq;
      int n;
      irq_req_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      irq_req_i = 1'b0;
      chk("masked irq", 16'h0000, got_irq);
      nmi_req_i = 1'b1;
      @(negedge clk_sys_i);
      nmi_req_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk("nmi taken", 16'h0001, got_nmi);
      settle();
      exec(16'h0190, 40'h4928341200, n);
      chk("branch pc", 16'h1234, pc_o);
      chk("branch irq en", 16'h0001, irq_en_o);
      irq_req_i = 1'b1;
      @(negedge clk_sys_i);
      irq_req_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk("irq taken", 16'h0001, got_irq);
      settle();
   endtask
   task automatic t_user_trap;
      int n;
      ret_addr_i = 16'h4321;
      exec(16'h01A0, 40'h4942000000, n);
      chk("return pc", 16'h4321, pc_o);
      chk("return user", 16'h0003, {user_mode_o, got_pop});
      reg_a_i = 8'h55;
      exec(16'h01B0, 40'h3A00000000, n);
      chk("trap base", 16'h0001, got_trap);
      chk("trap base kept", 16'h0012, base_o);
      chk("trap base pc", 16'h01B0, pc_o);
      reg_c_i = 8'h01;
      exec(16'h01C0, 40'h3F00000000, n);
      chk("trap map", 16'h0001, got_trap);
      chk("trap map pc", 16'h01C0, pc_o);
      sect(4'h0, 6'h17);
   endtask
   task automatic t_calls;
      int n;
      exec(16'h0200, 40'h3700000000, n);
      chk("call pc", 16'hEF2A, pc_o);
      chk("call push", 16'h0201, got_push);
      chk("call user", 16'h0000, user_mode_o);
      sect(4'hF, {4'hF, 1'b0, 1'b1});
      exec(16'h0210, 40'h3228000000, n);
      chk("leave pc", 16'h4321, pc_o);
      chk("leave flags", 16'h0007, {irq_en_o, user_mode_o, got_pop});
      exec(16'h0220, 40'h2A00000000, n);
      chk("brk pc", 16'hEF30, pc_o);
      chk("brk push", 16'h0221, got_push);
      chk("brk user", 16'h0000, user_mode_o);
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Run is about 960 cycles; this only catches a hang
   initial begin
      #100000;
      errors++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      chk("reset state", 16'h0000, {base_o, user_mode_o, irq_en_o, busy_o});
      t_dps();
      t_idx();
      t_lfi();
      t_base_skip();
      t_sml();
      t_irq();
      t_user_trap();
      t_calls();
      end_of_test();
   end
endmodule // os_control_and_index_ops_bench
